// ==== rtl/awf_cfg.svh ====
// Purpose: Constants for the asymmetric width FIFO (offsets, fields, widths, resets)
// Assumes: Single core_clk domain, plain register port
// Notes: Widths and depth fixed; register offsets chosen locally
// Overview of operation
// - Write to read width ratios 1:8 through 8:1 only, powers of two
// - Unequal widths only for separate-clock block-memory queues; here memory array always
// - Read depth equals write depth times write width over read width
// - Full and empty flags consider whole words only; partial words unreachable
// - At 4:1 from full, four reads free room for one write
// - Write count in write words, read count in read words
// - Narrow writes fill the read word from MSB downward
// - At 1:4, empty clears after four writes, sets after one read
// - Wide write word is read out MSB slice first
// - At 4:1, one write clears empty, four reads set it again
// - Lookahead mode holds two extra read words of capacity
// - Low level flag set while readable words at or below threshold
// - Low level flag may misbehave only while empty; threshold advice
// - Write count never under-reports except narrow-write partial words
// - Output pipeline delays read data and valid one more cycle
// - In lookahead mode the pipeline option changes nothing visible
// - Hard-primitive lookahead pipeline adds one cycle; not built here
// - Hard-primitive pipeline needs a single primitive deep; not built here
// - Hard-primitive pipeline only with a common clock
// - Read data output loads a configurable reset value
// - Default widths equal give a 1:1 ratio; here widths 8 and 2 give 4:1
// - Accepted transfers show in counts one full cycle later
`ifndef AWF_CFG_SVH
`define AWF_CFG_SVH

`define AWF_WR_W 8
`define AWF_RD_W 2
`define AWF_WR_DEPTH 16
`define AWF_EXTRA_RD_WORDS 2

`define AWF_ADDR_W 4
`define AWF_DATA_W 32
`define AWF_OFS_CTRL 4'h0
`define AWF_OFS_THRESH 4'h4
`define AWF_OFS_STATUS 4'h8
`define AWF_OFS_COUNTS 4'hc

`define AWF_CTRL_LOOKAHEAD 0
`define AWF_CTRL_PIPE 1
`define AWF_STAT_FULL 0
`define AWF_STAT_EMPTY 1
`define AWF_STAT_LOW 2
`define AWF_CNT_RD_LSB 16

`define AWF_CTRL_RST 2'h0
`define AWF_THRESH_RST 'h2
`define AWF_DOUT_RST 'h0

`endif

// ==== rtl/awf_fifo.sv ====
// Purpose: Asymmetric width FIFO with whole-word flags, counts and output options
// Assumes: Producer and consumer on core_clk; registers on a plain strobe port
// Notes: Storage is in atoms of the narrower width; words pack MSB first
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "awf_cfg.svh"
module awf_fifo
   import awf_pkg::*;
#(
   parameter logic [`AWF_RD_W-1:0] DOUT_RST = `AWF_DOUT_RST
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [`AWF_WR_W-1:0] wr_data,
   output logic full,
   output awf_count_t wr_count,
   input wire logic rd_en,
   output logic [`AWF_RD_W-1:0] rd_data,
   output logic rd_valid,
   output logic empty,
   output logic low_level_flag,
   output awf_count_t rd_count,
   input wire logic [`AWF_ADDR_W-1:0] reg_addr,
   input wire logic [`AWF_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`AWF_DATA_W-1:0] reg_rdata
);
   localparam int A = AWF_ATOM_W;
   localparam int WA = AWF_WA;
   localparam int RA = AWF_RA;
   localparam awf_count_t WA_C = awf_count_t'(AWF_WA);
   localparam awf_count_t RA_C = awf_count_t'(AWF_RA);
   localparam awf_count_t CAP_C = awf_count_t'(AWF_CAP);
   localparam awf_count_t MEM_C = awf_count_t'(AWF_MEM);

   logic rst_s1;
   logic rst_s2;
   logic [A-1:0] mem [AWF_MEM];
   awf_ptr_t wptr;
   awf_ptr_t rptr;
   awf_count_t used;
   awf_count_t thresh;
   awf_ctrl_t ctrl;
   awf_status_t stat;
   logic std_empty;
   logic [`AWF_RD_W-1:0] s1_data;
   logic s1_valid;

   logic w_acc;
   logic r_acc;
   awf_count_t cap_now;
   awf_count_t next_used;
   awf_count_t next_avail;
   awf_ptr_t next_wptr;
   awf_ptr_t next_rptr;
   logic [`AWF_RD_W-1:0] next_s1_data;
   logic next_s1_valid;
   logic next_full;
   logic next_std_empty;
   logic use_pipe;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   function automatic awf_ptr_t wrap_add(input awf_ptr_t p, input int n);
      int s;
      s = int'(p) + n;
      if (s >= AWF_MEM)
         s = s - AWF_MEM;
      return awf_ptr_t'(s);
   endfunction

   // Gather one read word, earliest atom into the MSBs
   function automatic logic [`AWF_RD_W-1:0] gather(input awf_ptr_t base);
      logic [`AWF_RD_W-1:0] w;
      w = '0;
      for (int i = 0; i < RA; i++)
         w[`AWF_RD_W-1-i*A -: A] = mem[wrap_add(base, i)];
      return w;
   endfunction

   always_comb
   begin
      w_acc = wr_en && !full;
      r_acc = rd_en && (ctrl.lookahead ? rd_valid : !std_empty);
      cap_now = ctrl.lookahead ? MEM_C : CAP_C;
      next_used = used + (w_acc ? WA_C : '0) - (r_acc ? RA_C : '0);
      next_avail = used - (r_acc ? RA_C : '0);
      next_wptr = w_acc ? wrap_add(wptr, WA) : wptr;
      next_rptr = r_acc ? wrap_add(rptr, RA) : rptr;
      next_full = next_used > (cap_now - WA_C);
      next_std_empty = next_used < RA_C;
      use_pipe = ctrl.pipe && !ctrl.lookahead;
      if (ctrl.lookahead)
      begin
         next_s1_data = gather(next_rptr);
         next_s1_valid = next_avail >= RA_C;
      end
      else
      begin
         next_s1_data = r_acc ? gather(rptr) : s1_data;
         next_s1_valid = r_acc;
      end
   end

   // Storage writes, wide word MSB slice to the earliest atom
   always_ff @(posedge core_clk)
   begin
      if (w_acc)
      begin
         for (int k = 0; k < WA; k++)
            mem[wrap_add(wptr, k)] <= wr_data[`AWF_WR_W-1-k*A -: A];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wptr <= '0;
         rptr <= '0;
         used <= '0;
         full <= 1'b0;
         std_empty <= 1'b1;
      end
      else if (!rst_s2)
      begin
         wptr <= '0;
         rptr <= '0;
         used <= '0;
         full <= 1'b0;
         std_empty <= 1'b1;
      end
      else
      begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         used <= next_used;
         full <= next_full;
         std_empty <= next_std_empty;
      end
   end

   // Read side data path; read data loads the reset value
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_data <= DOUT_RST;
         s1_valid <= 1'b0;
         rd_data <= DOUT_RST;
         rd_valid <= 1'b0;
         empty <= 1'b1;
      end
      else if (!rst_s2)
      begin
         s1_data <= DOUT_RST;
         s1_valid <= 1'b0;
         rd_data <= DOUT_RST;
         rd_valid <= 1'b0;
         empty <= 1'b1;
      end
      else
      begin
         s1_data <= next_s1_data;
         s1_valid <= next_s1_valid;
         rd_data <= use_pipe ? s1_data : next_s1_data;
         rd_valid <= use_pipe ? s1_valid : next_s1_valid;
         empty <= ctrl.lookahead ? !next_s1_valid : next_std_empty;
      end
   end

   // Counts lag the accepting edge by one cycle
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_count <= '0;
         rd_count <= '0;
         low_level_flag <= 1'b1;
      end
      else if (!rst_s2)
      begin
         wr_count <= '0;
         rd_count <= '0;
         low_level_flag <= 1'b1;
      end
      else
      begin
         wr_count <= (used + WA_C - awf_count_t'(1)) / WA_C;
         rd_count <= used / RA_C;
         low_level_flag <= (next_used / RA_C) <= thresh;
      end
   end

   // Register port
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl <= `AWF_CTRL_RST;
         thresh <= awf_count_t'(`AWF_THRESH_RST);
      end
      else if (!rst_s2)
      begin
         ctrl <= `AWF_CTRL_RST;
         thresh <= awf_count_t'(`AWF_THRESH_RST);
      end
      else if (reg_wr)
      begin
         if (reg_addr == `AWF_OFS_CTRL)
         begin
            ctrl.lookahead <= reg_wdata[`AWF_CTRL_LOOKAHEAD];
            ctrl.pipe <= reg_wdata[`AWF_CTRL_PIPE];
         end
         else if (reg_addr == `AWF_OFS_THRESH)
            thresh <= reg_wdata[AWF_CW-1:0];
      end
   end

   always_comb
   begin
      stat.full = full;
      stat.empty = empty;
      stat.low = low_level_flag;
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= '0;
      else if (!rst_s2 || !reg_rd)
         reg_rdata <= '0;
      else
      begin
         case (reg_addr)
            `AWF_OFS_CTRL:
               reg_rdata <= `AWF_DATA_W'(ctrl);
            `AWF_OFS_THRESH:
               reg_rdata <= `AWF_DATA_W'(thresh);
            `AWF_OFS_STATUS:
               reg_rdata <= `AWF_DATA_W'(stat);
            `AWF_OFS_COUNTS:
               reg_rdata <= (`AWF_DATA_W'(rd_count) << `AWF_CNT_RD_LSB) | `AWF_DATA_W'(wr_count);
            default:
               reg_rdata <= '0;
         endcase
      end
   end

   // Checks
   sequence s_std_read;
      r_acc && !ctrl.lookahead && !ctrl.pipe && $stable(ctrl);
   endsequence

   sequence s_pipe_read;
      r_acc && !ctrl.lookahead && ctrl.pipe && $stable(ctrl);
   endsequence

   a_ratio_legal: assert property (@(posedge core_clk) disable iff (!rst_s2)
      ((WA == 1) || (RA == 1)) && ((WA * RA) inside {1, 2, 4, 8}))
      else $error("illegal width ratio");

   a_no_overflow: assert property (@(posedge core_clk) disable iff (!rst_s2)
      used <= cap_now)
      else $error("occupancy above capacity");

   a_whole_read: assert property (@(posedge core_clk) disable iff (!rst_s2)
      !std_empty |-> used >= RA_C)
      else $error("empty cleared without a whole read word");

   a_full_room: assert property (@(posedge core_clk) disable iff (!rst_s2)
      !full && !ctrl.lookahead |-> used <= CAP_C - WA_C)
      else $error("full clear without room for a write word");

   a_ignore_full: assert property (@(posedge core_clk) disable iff (!rst_s2)
      wr_en && full && !r_acc |=> used == $past(used) && wptr == $past(wptr))
      else $error("write accepted while full");

   a_count_lag: assert property (@(posedge core_clk) disable iff (!rst_s2)
      w_acc && !r_acc && !$past(w_acc) |=> ##1 rd_count == ($past(used, 1) / RA_C))
      else $error("read count not one cycle behind");

   a_std_latency: assert property (@(posedge core_clk) disable iff (!rst_s2)
      s_std_read |=> rd_valid)
      else $error("standard read valid not after one cycle");

   a_pipe_latency: assert property (@(posedge core_clk) disable iff (!rst_s2)
      s_pipe_read ##1 $stable(ctrl) |=> rd_valid)
      else $error("pipelined read valid not after two cycles");

   a_low_level: assert property (@(posedge core_clk) disable iff (!rst_s2)
      $stable(thresh) |=> low_level_flag == (($past(next_used) / RA_C) <= $past(thresh)))
      else $error("low level flag disagrees with threshold");

   a_lookahead_cap: assert property (@(posedge core_clk) disable iff (!rst_s2)
      ctrl.lookahead && !full |-> used <= MEM_C - WA_C)
      else $error("lookahead capacity exceeded");

endmodule // awf_fifo
`default_nettype wire

// ==== rtl/awf_pkg.sv ====
// Purpose: Types shared by the asymmetric width FIFO
// Assumes: awf_cfg.svh defines the widths
// Notes: Counts are wide enough for the lookahead capacity
`include "awf_cfg.svh"
package awf_pkg;
   localparam int AWF_ATOM_W = (`AWF_WR_W < `AWF_RD_W) ? `AWF_WR_W : `AWF_RD_W;
   localparam int AWF_WA = `AWF_WR_W / AWF_ATOM_W;
   localparam int AWF_RA = `AWF_RD_W / AWF_ATOM_W;
   localparam int AWF_CAP = `AWF_WR_DEPTH * AWF_WA;
   localparam int AWF_MEM = AWF_CAP + `AWF_EXTRA_RD_WORDS * AWF_RA;
   localparam int AWF_CW = $clog2(AWF_MEM + 1);
   localparam int AWF_IW = $clog2(AWF_MEM);

   typedef logic [AWF_CW-1:0] awf_count_t;
   typedef logic [AWF_IW-1:0] awf_ptr_t;

   typedef struct packed {
      logic pipe;
      logic lookahead;
   } awf_ctrl_t;

   typedef struct packed {
      logic low;
      logic empty;
      logic full;
   } awf_status_t;
endpackage

// ==== testbench/asymmetric_width_fifo_bench.sv ====
// Purpose: Self-checking bench for awf_fifo
// Assumes: 4:1 widths, depth 16 write words
// Notes: A monitor checks every read slice against a queue
`timescale 1ns/1ps
`default_nettype none
`include "awf_cfg.svh"
module asymmetric_width_fifo_bench
   import awf_pkg::*;
;
   typedef struct packed {
      logic [7:0] w;
      logic [3:0][1:0] e;
   } awf_row_t;
   awf_row_t rows [5] = '{'{8'hc7, {2'h3, 2'h0, 2'h1, 2'h3}}, '{8'h1b, {2'h0, 2'h1, 2'h2, 2'h3}},
      '{8'he4, {2'h3, 2'h2, 2'h1, 2'h0}}, '{8'hff, {2'h3, 2'h3, 2'h3, 2'h3}}, '{8'h00, 8'h00}};
   logic core_clk, rst_b, gate, wr_req, rd_req, wr_en, rd_en, full, empty, rd_valid, low_level_flag;
   logic reg_wr, reg_rd;
   logic [7:0] wr_word, wr_data;
   logic [1:0] rd_data;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   awf_count_t wr_count, rd_count;
   logic [1:0] exp_q [$];
   int n_mismatch, n_tests;
   bit la;

   awf_fifo #(.DOUT_RST(2'h2)) dut (.core_clk(core_clk), .rst_b(rst_b), .wr_en(wr_en), .wr_data(wr_data),
      .full(full), .wr_count(wr_count), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
      .empty(empty), .low_level_flag(low_level_flag), .rd_count(rd_count), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   awf_user user (.gate(gate), .wr_req(wr_req), .wr_word(wr_word), .full(full), .rd_req(rd_req),
      .empty(empty), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wr_words(input int n, input logic [7:0] base, input bit keep);
      logic [7:0] w;
      for (int i = 0; i < n; i++)
      begin
         w = base + 8'(i);
         @(posedge core_clk);
         wr_req <= 1'b1;
         wr_word <= w;
         if (keep)
            for (int k = 3; k >= 0; k--)
               exp_q.push_back(w[2*k+:2]);
      end
      @(posedge core_clk);
      wr_req <= 1'b0;
   endtask

   task automatic rd_slices(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         rd_req <= 1'b1;
      end
      @(posedge core_clk);
      rd_req <= 1'b0;
   endtask

   task automatic wait_chk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic reg_put(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_chk(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata === d, "register read");
   endtask

   always @(posedge core_clk)
      if (rst_b && rd_valid === 1'b1 && (!la || rd_en === 1'b1))
      begin
         if (exp_q.size() == 0)
            chk(1'b0, "unexpected read data");
         else
            chk(rd_data === exp_q.pop_front(), "read slice");
      end

   initial
   begin
      #(8 * 6000);
      n_mismatch++;
      end_sim();
   end

   initial
   begin
      {rst_b, wr_req, rd_req, reg_wr, reg_rd, wr_word, reg_addr, reg_wdata} = '0;
      gate = 1'b1;
      wait_chk(5);
      chk(full === 1'b0 && empty === 1'b1 && rd_valid === 1'b0, "reset flags");
      chk(rd_data === 2'h2 && wr_count === '0 && rd_count === '0, "reset data");
      wait_chk(5);
      rst_b <= 1'b1;
      wait_chk(3);
      reg_chk(`AWF_OFS_THRESH, 32'h2);
      reg_put(4'h2, 32'hffff_ffff);
      reg_chk(4'h2, 32'h0);
      $display("reset done");
      foreach (rows[r])
      begin
         wr_words(1, rows[r].w, 1'b0);
         for (int k = 3; k >= 0; k--)
            exp_q.push_back(rows[r].e[k]);
         #1;
         chk(empty === 1'b0 && rd_count === '0, "one write");
         wait_chk(1);
         chk(rd_count === 7'd4 && wr_count === 7'd1, "counts");
         rd_slices(4);
         wait_chk(3);
         chk(empty === 1'b1 && exp_q.size() == 0, "four reads");
      end
      $display("table done");
      wr_words(1, 8'h5a, 1'b1);
      wait_chk(3);
      chk(low_level_flag === 1'b0, "level above");
      reg_put(`AWF_OFS_THRESH, 32'h4);
      wait_chk(3);
      chk(low_level_flag === 1'b1, "level at");
      reg_put(`AWF_OFS_THRESH, 32'h2);
      rd_slices(2);
      wait_chk(3);
      chk(low_level_flag === 1'b1, "level after reads");
      rd_slices(2);
      reg_chk(`AWF_OFS_STATUS, 32'h6);
      $display("level done");
      gate = 1'b0;
      wr_words(16, 8'h10, 1'b1);
      wr_words(1, 8'hee, 1'b0);
      wait_chk(2);
      chk(full === 1'b1 && wr_count === 7'd16 && rd_count === 7'd64, "full");
      rd_slices(3);
      wait_chk(3);
      chk(full === 1'b1, "partial room");
      rd_slices(1);
      wait_chk(3);
      chk(full === 1'b0, "word room");
      wr_words(1, 8'h3c, 1'b1);
      rd_slices(65);
      wait_chk(3);
      chk(empty === 1'b1 && rd_count === '0 && exp_q.size() == 0, "drained");
      $display("fill done");
      gate = 1'b1;
      reg_put(`AWF_OFS_CTRL, 32'h2);
      wr_words(1, 8'h9c, 1'b1);
      wait_chk(2);
      rd_slices(1);
      #1;
      chk(rd_valid === 1'b0, "pipe delay");
      wait_chk(1);
      chk(rd_valid === 1'b1 && rd_data === 2'h2, "pipe data");
      rd_slices(3);
      wait_chk(4);
      chk(empty === 1'b1 && exp_q.size() == 0, "pipe drained");
      $display("pipe done");
      reg_put(`AWF_OFS_CTRL, 32'h3);
      la = 1'b1;
      wr_words(1, 8'h63, 1'b1);
      wait_chk(3);
      chk(rd_valid === 1'b1 && rd_data === 2'h1 && empty === 1'b0, "lookahead head");
      rd_slices(4);
      wait_chk(3);
      chk(empty === 1'b1 && rd_valid === 1'b0 && exp_q.size() == 0, "lookahead drained");
      $display("lookahead done");
      end_sim();
   end
endmodule // asymmetric_width_fifo_bench
`default_nettype wire

// ==== testbench/awf_user.sv ====
// Purpose: Producer and consumer logic beside the FIFO ports
// Assumes: Requests come from the bench
// Notes: gate high makes requests obey full and empty
`timescale 1ns/1ps
`default_nettype none
module awf_user (
   input wire logic gate,
   input wire logic wr_req,
   input wire logic [7:0] wr_word,
   input wire logic full,
   input wire logic rd_req,
   input wire logic empty,
   output logic wr_en,
   output logic [7:0] wr_data,
   output logic rd_en
);
   assign wr_en = wr_req && !(gate && full);
   assign rd_en = rd_req && !(gate && empty);
   // Idle data inverted so stale words never match
   assign wr_data = wr_en ? wr_word : ~wr_word;
endmodule // awf_user
`default_nettype wire
